// ==== two_wire_slave_transmitter_tb_top.sv ====
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_transmitter_tb_top
  import tws_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h35;
  localparam logic [31:0] EN = 32'h04;
  localparam logic [31:0] ACK = 32'h40;
  localparam logic [31:0] FLAG = 32'h80;
  localparam logic [7:0] RSTV [0:6] = '{8'h00, 8'h00, 8'hF8, 8'hFF,
    8'h00, 8'h00, 8'h00};
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready, arb;
  logic awready, wready, bvalid, rvalid, scl_out, scl_oe, sda_out, sda_oe;
  logic irq, scl_low, sda_low, hung, ack, arready;
  logic [7:0] awaddr, araddr, got;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [33:0] notes [$];
  logic [1:0] wnotes [$];
  wire logic scl_w, sda_w;
  int bad_count, checks, i;
  // pulled-up wires: any party pulling low wins
  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);
  tws_slave_tx DUT (
    .core_clk(core_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .master_arb_lost(arb), .irq(irq)
  );
  tws_bus_master MST (
    .scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low),
    .hung(hung)
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic fail_now();
    bad_count++;
    wrap_up();
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp34(input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // each half is released at its own handshake; bready trails bvalid so
  // the response must stand for a cycle while it is not yet taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r = RESP_OKAY);
    int n;
    wnotes.push_back(r);
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (bvalid && bready) break;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 100) fail_now();
  endtask
  // the expected word goes to the note queue before the request
  task automatic rd(input logic [7:0] a, input logic [7:0] v,
    input logic [1:0] r);
    int n;
    notes.push_back({r, 24'h0, v});
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (rvalid && rready) break;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 100) fail_now();
  endtask
  // waits for the event interrupt, then clears its sticky bit
  task automatic wait_irq();
    int n;
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk);
    if (n == 400) fail_now();
    wr(OFS_IRQ_ST, 32'h1);
  endtask
  // read answers are matched against the oldest note
  always @(posedge core_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) cmp34(notes.pop_front(),
      {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) cmp8({6'h0, wnotes.pop_front()},
      {6'h0, bresp});
  end
  always @(posedge hung) fail_now();
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, arb} = 7'h40;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    bad_count = 0;
    checks = 0;
    seed = 32'h8DB3;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd(8'(i * 4), RSTV[i],
      (i == 6) ? RESP_SLVERR : RESP_OKAY);
    wr(8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_OWN, {24'h0, ADDR, 1'b0});
    rd(OFS_OWN, {ADDR, 1'b0}, RESP_OKAY);
    wr(OFS_IRQ_MK, 32'h1);
    // pass 0 ends with a nack, pass 1 with an ack after lost arbitration
    for (i = 0; i < 2; i++) begin
      wr(OFS_CTRL, EN);
      MST.start();
      MST.put({ADDR, 1'b1}, ack);
      cmp8(8'h00, {7'h0, ack});
      cmp8(8'h00, {6'h0, scl_out, sda_out});
      MST.stop();
      wr(OFS_CTRL, EN | ACK);
      if (i == 1) begin
        @(posedge core_clk);
        arb <= 1'b1;
        @(posedge core_clk);
        arb <= 1'b0;
      end
      MST.start();
      MST.put({ADDR, 1'b1}, ack);
      cmp8(8'h01, {7'h0, ack});
      wait_irq();
      rd(OFS_STAT, (i == 1) ? CODE_ARB_READ : 8'hA8, RESP_OKAY);
      seed = lfsr(seed);
      wr(OFS_DATA, {24'h0, seed[7:0]});
      wr(OFS_CTRL, FLAG | EN | ACK);
      MST.get(1'b1, got);
      cmp8(seed[7:0], got);
      wait_irq();
      rd(OFS_STAT, 8'hB8, RESP_OKAY);
      seed = lfsr(seed);
      wr(OFS_DATA, {24'h0, seed[7:0]});
      wr(OFS_CTRL, FLAG | EN);
      MST.get(i[0], got);
      cmp8(seed[7:0], got);
      wait_irq();
      rd(OFS_STAT, i[0] ? CODE_LAST_ACK : CODE_LAST_NACK, RESP_OKAY);
      wr(OFS_CTRL, FLAG | EN | ACK);
      if (i == 1) begin
        MST.get(1'b0, got);
        cmp8(8'hFF, got);
      end
      MST.stop();
    end
    MST.start();
    MST.put({ADDR ^ 7'h01, 1'b1}, ack);
    cmp8(8'h00, {7'h0, ack});
    MST.stop();
    // general call answered only with bit 0 of the own address set
    for (i = 0; i < 2; i++) begin
      wr(OFS_OWN, {24'h0, ADDR, i[0]});
      MST.start();
      MST.put(GC_ADDR, ack);
      cmp8({7'h0, i[0]}, {7'h0, ack});
      if (i == 1) begin
        rd(OFS_STAT, 8'h60, RESP_OKAY);
        cmp8(8'h01, {7'h0, irq});
        wr(OFS_IRQ_MK, 32'h0);
        cmp8(8'h00, {7'h0, irq});
        wr(OFS_IRQ_MK, 32'h1);
        wr(OFS_IRQ_ST, 32'h1);
        cmp8(8'h00, {7'h0, irq});
        wr(OFS_CTRL, FLAG | EN | ACK);
      end
      MST.stop();
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== tws_bus_master.sv ====
// two-wire master receiver model that waits out clock stretching
`timescale 1ns/1ps
`default_nettype none
module tws_bus_master (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_low,
  output logic sda_low,
  output logic hung
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung = 1'b0;
  end
  // one bit slot; data moves only while the clock is low
  task automatic slot(input logic b, output logic r);
    int n;
    sda_low = !b;
    #40;
    scl_low = 1'b0;
    for (n = 0; n < 4000 && scl_w !== 1'b1; n++) #5;
    if (n == 4000) hung = 1'b1;
    #40;
    r = sda_w;
    #40;
    scl_low = 1'b1;
    #40;
  endtask
  task automatic start();
    sda_low = 1'b0;
    scl_low = 1'b0;
    #80;
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #40;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b0;
    #80;
    sda_low = 1'b0;
    #80;
  endtask
  // address byte out msb first; a low ninth bit is the slave's ack
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    int i;
    for (i = 7; i >= 0; i--) slot(v[i], r);
    slot(1'b1, r);
    ack = !r;
  endtask
  // released line reads the pull-up, so an absent slave gives ones
  task automatic get(input logic ack, output logic [7:0] v);
    logic r;
    int i;
    for (i = 7; i >= 0; i--) begin
      slot(1'b1, r);
      v[i] = r;
    end
    slot(!ack, r);
  endtask
endmodule
`default_nettype wire

// ==== tws_line_if.sv ====
// synchronised bus line levels and events between sampler and engine
`timescale 1ns/1ps
`default_nettype none
interface tws_line_if;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport src (output sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
  modport dst (input sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
endinterface
`default_nettype wire

// ==== tws_pin_sync.sv ====
// two-stage synchronisers and edge, start and stop detection for the pins
`timescale 1ns/1ps
`default_nettype none
module tws_pin_sync
  import tws_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  tws_line_if.src ln
);
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  // first stage feeds only the second; third stage gives the edge history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end

  // data change while clock high marks start or stop
  assign ln.sda_lvl = sda_s;
  assign ln.scl_rise = scl_s & ~scl_d;
  assign ln.scl_fall = ~scl_s & scl_d;
  assign ln.start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign ln.stop_seen = scl_s & scl_d & ~sda_d & sda_s;
endmodule
`default_nettype wire

// ==== tws_pkg.sv ====
// constants, types and decode helpers for the two-wire slave transmitter
// Notes on behaviour
// - The upper seven own-address bits are the slave address and bit 0 enables answering general call 0x00.
// - Own or general call address is acknowledged only while ack_enable is one.
// - A matching address with direction one enters slave transmit, otherwise slave receive.
// - After own address and direction are received the flag is set and a valid status code is shown.
// - A read address after lost master arbitration enters slave transmit with status 0xB0.
// - With ack_enable cleared the current byte is the last and ends in 0xC0 on NACK or 0xC8 on ACK.
// - After the last byte the block is unaddressed and the master only reads ones.
// - Status 0xC8 is reported when the master acknowledges the final byte.
// - While ack_enable is zero the own address is ignored but the bus is still watched.
// - Setting ack_enable again restores address recognition at any moment.
// - While the flag is set the clock line is held low.
// - Writing one to the flag clears it and no new bus operation starts while it is set.
package tws_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_OWN = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MK = 8'h14;
  // bus_control bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;
  // interrupt status bit positions and width
  localparam int IRQ_EVT = 0;
  localparam int IRQ_WCOL = 1;
  localparam int IRQ_W = 2;
  // fixed status codes and the general call address
  localparam logic [7:0] CODE_ARB_READ = 8'hB0;
  localparam logic [7:0] CODE_LAST_NACK = 8'hC0;
  localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
  localparam logic [7:0] GC_ADDR = 8'h00;
  // reset values, bits per byte and response codes
  localparam logic [7:0] RST_OWN = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register index returned by the decoder
  localparam logic [2:0] IDX_OWN = 3'h0;
  localparam logic [2:0] IDX_CTRL = 3'h1;
  localparam logic [2:0] IDX_STAT = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam logic [2:0] IDX_IRQ_ST = 3'h4;
  localparam logic [2:0] IDX_IRQ_MK = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_WAIT = 3'b011,
    S_TX = 3'b100,
    S_TACK = 3'b101,
    S_SRX = 3'b110
  } tws_state_e;

  // address decode shared by the read and write paths
  function automatic logic [2:0] tws_reg_idx(input logic [7:0] a);
    case (a)
      OFS_OWN: return IDX_OWN;
      OFS_CTRL: return IDX_CTRL;
      OFS_STAT: return IDX_STAT;
      OFS_DATA: return IDX_DATA;
      OFS_IRQ_ST: return IDX_IRQ_ST;
      OFS_IRQ_MK: return IDX_IRQ_MK;
      default: return IDX_NONE;
    endcase
  endfunction
endpackage

// ==== tws_shift.sv ====
// byte shift register, msb leaves first, new bits enter at the bottom
`timescale 1ns/1ps
`default_nettype none
module tws_shift #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic shift_en,
  input wire logic shift_bit,
  output logic [WIDTH-1:0] q
);
  // load wins over shift; both never coincide in the engine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '1;
    end else if (load) begin
      q <= load_val;
    end else if (shift_en) begin
      q <= {q[WIDTH-2:0], shift_bit};
    end
  end
endmodule
`default_nettype wire

// ==== tws_slave_tx.sv ====
// two-wire slave transmitter with an axi4-lite register port
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tx
  import tws_pkg::*;
#(
  parameter logic [7:0] IDLE_CODE = 8'hF8,
  parameter logic [7:0] ST_ADDR_CODE = 8'hA8,
  parameter logic [7:0] ST_DATA_ACK_CODE = 8'hB8,
  parameter logic [7:0] SR_ADDR_CODE = 8'h60
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic master_arb_lost,
  output logic irq
);
  tws_line_if ln ();
  tws_state_e state;
  logic [7:0] own_slave_address;
  logic [7:0] bus_data_byte;
  logic [7:0] bus_status_code;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic bus_event_flag, ack_enable, start_request, stop_request;
  logic write_collision_flag, interface_enable, event_irq_enable;
  logic sda_drive, scl_hold, last_byte, read_dir, arb_pend, master_ack;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_en, ar_fire;
  logic [2:0] w_idx, r_idx;
  logic addr_hit, set_flag, clr_flag, wcol_evt, data_wr;
  logic sh_load, sh_shift, sh_bit;
  logic [7:0] next_code;
  logic [31:0] next_rdata;

  tws_pin_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ln(ln)
  );

  tws_shift #(.WIDTH(8)) u_shift (
    .core_clk(core_clk),
    .rst(rst),
    .load(sh_load),
    .load_val(bus_data_byte),
    .shift_en(sh_shift),
    .shift_bit(sh_bit),
    .q(shreg)
  );

  // open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_hold;
  assign sda_oe = sda_drive;

  // address match; general call is only a write address
  assign addr_hit = ack_enable &
    ((shreg[7:1] == own_slave_address[7:1]) |
     (own_slave_address[0] & (shreg[7:1] == GC_ADDR[7:1]) & ~shreg[0]));

  // shifter control: address bits enter on rise, data leaves on fall
  assign sh_load = (state == S_WAIT) & ~bus_event_flag;
  assign sh_shift = ((state == S_ADDR) & ln.scl_rise &
                     (bit_cnt != BITS_PER_BYTE)) |
                    ((state == S_TX) & ln.scl_fall);
  assign sh_bit = (state == S_ADDR) ? ln.sda_lvl : 1'b1;

  // flag events at the fall closing an acknowledge bit
  assign set_flag = ln.scl_fall & ((state == S_AACK) | (state == S_TACK));

  // status code chosen for the coming flag event
  always_comb begin
    next_code = IDLE_CODE;
    if (state == S_AACK) begin
      if (!read_dir) begin
        next_code = SR_ADDR_CODE;
      end else if (arb_pend) begin
        next_code = CODE_ARB_READ;
      end else begin
        next_code = ST_ADDR_CODE;
      end
    end else if (!master_ack) begin
      next_code = CODE_LAST_NACK;
    end else if (last_byte) begin
      next_code = CODE_LAST_ACK;
    end else begin
      next_code = ST_DATA_ACK_CODE;
    end
  end

  // bus engine; edges are ignored while the clock is being held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
      read_dir <= 1'b0;
      last_byte <= 1'b0;
      master_ack <= 1'b0;
    end else if (!interface_enable || ln.stop_seen) begin
      state <= S_IDLE;
      sda_drive <= 1'b0;
    end else if (ln.start_seen && !bus_event_flag) begin
      state <= S_ADDR;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        S_ADDR: begin
          if (ln.scl_rise && bit_cnt != BITS_PER_BYTE) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (ln.scl_fall && bit_cnt == BITS_PER_BYTE) begin
            if (addr_hit) begin
              sda_drive <= 1'b1;
              read_dir <= shreg[0];
              state <= S_AACK;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (ln.scl_fall) begin
            sda_drive <= 1'b0;
            state <= read_dir ? S_WAIT : S_SRX;
          end
        end
        S_WAIT: begin
          if (!bus_event_flag) begin
            last_byte <= ~ack_enable;
            sda_drive <= ~bus_data_byte[7];
            bit_cnt <= 4'h0;
            state <= S_TX;
          end
        end
        S_TX: begin
          if (ln.scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              sda_drive <= 1'b0;
              state <= S_TACK;
            end else begin
              sda_drive <= ~shreg[6];
            end
          end
        end
        S_TACK: begin
          if (ln.scl_rise) begin
            master_ack <= ~ln.sda_lvl;
          end
          if (ln.scl_fall) begin
            // after the last byte stay off the line: master reads ones
            state <= (!master_ack || last_byte) ? S_IDLE : S_WAIT;
          end
        end
        S_SRX: begin
          state <= S_SRX; // receive path waits for stop or start
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // clock stretch begins at the flag's fall and ends the cycle after the flag clears
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_hold <= 1'b0;
    end else if (set_flag) begin
      scl_hold <= 1'b1;
    end else if (!bus_event_flag) begin
      scl_hold <= 1'b0;
    end
  end

  // arbitration loss from the master side is remembered until addressed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arb_pend <= 1'b0;
    end else if (master_arb_lost) begin
      arb_pend <= 1'b1;
    end else if (set_flag && state == S_AACK) begin
      arb_pend <= 1'b0;
    end
  end

  // axi write: address and data are taken independently, then applied
  assign awready = ~aw_hold & ~bvalid;
  assign wready = ~w_hold & ~bvalid;
  assign wr_fire = aw_hold & w_hold & ~bvalid;
  assign w_idx = tws_reg_idx(aw_addr);
  assign wr_en = wr_fire & w_strb[0];
  assign arready = ~rvalid;
  assign ar_fire = arvalid & ~rvalid;
  assign r_idx = tws_reg_idx(araddr);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (w_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // writable control and address fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      own_slave_address <= RST_OWN;
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      interface_enable <= 1'b0;
      event_irq_enable <= 1'b0;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (w_idx)
        IDX_OWN: own_slave_address <= w_data[7:0];
        IDX_CTRL: begin
          ack_enable <= w_data[CTL_ACK];
          start_request <= w_data[CTL_STA];
          stop_request <= w_data[CTL_STO];
          interface_enable <= w_data[CTL_EN];
          event_irq_enable <= w_data[CTL_IE];
        end
        IDX_IRQ_MK: irq_mask <= w_data[IRQ_W-1:0];
        default: own_slave_address <= own_slave_address;
      endcase
    end
  end

  // data byte; a write while the bus owns it is a collision
  assign data_wr = wr_en & (w_idx == IDX_DATA);
  assign wcol_evt = data_wr & ~bus_event_flag;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_data_byte <= RST_DATA;
      write_collision_flag <= 1'b0;
    end else if (wcol_evt) begin
      write_collision_flag <= 1'b1;
    end else if (data_wr) begin
      bus_data_byte <= w_data[7:0];
      write_collision_flag <= 1'b0;
    end
  end

  // flag and status; a hardware set beats a same-cycle software clear
  assign clr_flag = wr_en & (w_idx == IDX_CTRL) & w_data[CTL_FLAG];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_event_flag <= 1'b0;
      bus_status_code <= IDLE_CODE;
    end else if (set_flag) begin
      bus_event_flag <= 1'b1;
      bus_status_code <= next_code;
    end else if (clr_flag) begin
      bus_event_flag <= 1'b0;
      bus_status_code <= IDLE_CODE;
    end
  end

  // sticky interrupt causes, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_EVT && set_flag) || (i == IRQ_WCOL && wcol_evt)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_en && w_idx == IDX_IRQ_ST && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read mux; unused bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (r_idx)
      IDX_OWN: next_rdata[7:0] = own_slave_address;
      IDX_CTRL: begin
        next_rdata[CTL_FLAG] = bus_event_flag;
        next_rdata[CTL_ACK] = ack_enable;
        next_rdata[CTL_STA] = start_request;
        next_rdata[CTL_STO] = stop_request;
        next_rdata[CTL_WCOL] = write_collision_flag;
        next_rdata[CTL_EN] = interface_enable;
        next_rdata[CTL_IE] = event_irq_enable;
      end
      IDX_STAT: next_rdata[7:0] = bus_status_code;
      IDX_DATA: next_rdata[7:0] = bus_data_byte;
      IDX_IRQ_ST: next_rdata[IRQ_W-1:0] = irq_status;
      IDX_IRQ_MK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= (r_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tws_slave_tx_assertions.sv ====
// port checker for the two-wire slave transmitter
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tx_assertions
  import tws_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic irq
);
  logic [3:0] since_wr;
  // cycles since a write address was taken, saturating at 15
  always_ff @(posedge core_clk) begin
    if (rst || (awvalid && awready)) begin
      since_wr <= 4'h0;
    end else if (since_wr != 4'hF) begin
      since_wr <= since_wr + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_wr_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write response missing");
  chk_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_rd_answer: assert property (arvalid && !rvalid |=> rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_reset_idle: assert property ($fell(rst) |-> !irq && !scl_oe && !sda_oe
    && !bvalid && !rvalid) else $error("outputs busy after reset");
  chk_stretch_at_fall: assert property ($rose(scl_oe) |->
    !scl_in && $past(scl_in, 2) == 1'b0) else $error("stretch off a low");
  chk_stretch_release: assert property ($fell(scl_oe) |->
    since_wr < 4'h6) else $error("clock released without a write");
  chk_sda_change: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  cover property ($rose(scl_oe));
  cover property ($rose(irq));
  cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind tws_slave_tx tws_slave_tx_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire
